// ===== inc/autoloader_map.svh
// Register offsets, field positions, reset values and timing counts of the autoloader controller
`ifndef AUTOLOADER_MAP_SVH
`define AUTOLOADER_MAP_SVH

`define CLK_KHZ 100000
`define LAMP_TIME_MS 1500
`define LAMP_CYCLES (`LAMP_TIME_MS * `CLK_KHZ)
`define BLINK_HALF_MS 250
`define BLINK_HALF_CYCLES (`BLINK_HALF_MS * `CLK_KHZ)

`define OFF_CTRL 8'h00
`define OFF_CMD 8'h04
`define OFF_SELECT 8'h08
`define OFF_FAULT 8'h0C
`define OFF_STATUS 8'h10
`define OFF_LEDS 8'h14

`define CTRL_SEQ_BIT 0
`define CTRL_RESTART_BIT 1
`define CTRL_LOOP_BIT 2
`define CTRL_SEQ_RST 1'b0
`define CTRL_RESTART_RST 1'b1
`define CTRL_LOOP_RST 1'b0
`define FAULT_CLR_BIT 8

`define OP_MOVE 8'h0A
`define OP_POSITION 8'h2B

`define LOC_DRIVE 4'h0
`define SLOT_FIRST 4'h1
`define SLOT_LAST 4'hA
`define LED_COUNT 10

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== inc/autoloader_pkg.sv
// Types shared by the autoloader controller files
package autoloader_pkg;

   typedef enum logic [3:0] {
      ST_LAMP = 4'h0,
      ST_SELFTEST = 4'h1,
      ST_RND_IDLE = 4'h2,
      ST_RND_PICK = 4'h3,
      ST_RND_PLACE = 4'h4,
      ST_RND_POS = 4'h5,
      ST_SEQ_WAIT = 4'h6,
      ST_SEQ_PICK = 4'h7,
      ST_SEQ_INSERT = 4'h8,
      ST_SEQ_CLOSE = 4'h9,
      ST_SEQ_PARK = 4'hA,
      ST_SEQ_REOPEN = 4'hB,
      ST_SEQ_RETRIEVE = 4'hC,
      ST_SEQ_RETURN = 4'hD,
      ST_SEQ_HALT = 4'hE,
      ST_FAULT = 4'hF
   } state_t;

   typedef enum logic [3:0] {
      ACT_NONE = 4'h0,
      ACT_HOME_TOP = 4'h1,
      ACT_PICK_SLOT = 4'h2,
      ACT_PLACE_DRIVE = 4'h3,
      ACT_CLOSE_DOOR = 4'h4,
      ACT_PARK = 4'h5,
      ACT_PICK_DRIVE = 4'h6,
      ACT_PLACE_SLOT = 4'h7,
      ACT_POSITION = 4'h8
   } act_t;

endpackage : autoloader_pkg

// ===== hw/blink_divider.sv
// Free-running divider that sets the common blink phase of the panel
`timescale 1ns/1ps
module blink_divider #(
   parameter int HALF_CYCLES = 25000000
)(
   input wire logic clk, // System clock
   input wire logic rst, // Asynchronous reset, active high
   output logic phase // Blink phase, toggles every half period
);

   logic [27:0] cnt_reg;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_reg <= 28'h0000000;
         phase <= 1'b0;
      end
      else if (cnt_reg == 28'(HALF_CYCLES - 1))
      begin
         cnt_reg <= 28'h0000000;
         phase <= ~phase;
      end
      else
      begin
         cnt_reg <= cnt_reg + 28'h0000001;
      end
   end

endmodule : blink_divider

// ===== hw/autoloader_sequence_control.sv
// Autoloader sequence controller with AXI4-Lite register slave
`timescale 1ns/1ps
`include "autoloader_map.svh"

module autoloader_sequence_control #(
   parameter int LAMP_CYCLES = `LAMP_CYCLES,
   parameter int BLINK_HALF_CYCLES = `BLINK_HALF_CYCLES
)(
   input wire logic clk, // System clock, 100 MHz
   input wire logic rst, // Asynchronous reset, active high
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic door_open_pin, // Drive door switch, high while open
   input wire logic holder_swap_pin, // Holder replaced pulse from sensor
   input wire logic act_done_pin, // Handler finished current action
   input wire logic act_empty_pin, // Handler found nothing to pick
   input wire logic act_fault_pin, // Handler reports a fault
   input wire logic [7:0] fault_code_pin, // Handler fault code
   input wire logic [3:0] nv_resume_slot, // Stored slot of interrupted work
   output logic act_req, // Handler action request, held until done or fault
   output autoloader_pkg::act_t act_code, // Handler action
   output logic [3:0] act_loc, // Action location, 0 drive, 1 to 10 slots
   output logic [`LED_COUNT-1:0] led // Panel lamps, bit 0 is the bottom lamp
);
   import autoloader_pkg::*;

   state_t state_reg;
   logic [12:0] sync1_reg, sync2_reg;
   logic door_s, holder_s, done_s, empty_s, fault_s, blink;
   logic [7:0] code_s, fault_code_reg, cmd_op_reg, awaddr_q;
   logic [27:0] lamp_cnt_reg;
   logic seq_mode_reg, restart_reg, loop_reg;
   logic [3:0] cmd_src_reg, cmd_dst_reg, ex_src_reg, ex_dst_reg;
   logic cmd_pend_reg, sel_pend_reg, rejected_reg, aw_full_reg, w_full_reg;
   logic [3:0] sel_slot_reg, slot_reg;
   logic [9:0] done_mask_reg;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_fire, wr_ctrl, wr_cmd, wr_sel, wr_fclr, wr_hit, rd_hit;
   logic [31:0] rd_mux;
   act_t cur_act;
   logic [3:0] cur_loc;
   logic seq_grp, seq_busy, cmd_ack, cmd_ok, sel_ack, issue, step;
   logic [9:0] slot_bit;

   // Pins pass two flip-flops before use
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sync1_reg <= 13'h0000;
         sync2_reg <= 13'h0000;
      end
      else
      begin
         sync1_reg <= {fault_code_pin, act_fault_pin, act_empty_pin, act_done_pin, holder_swap_pin, door_open_pin};
         sync2_reg <= sync1_reg;
      end
   end
   assign {code_s, fault_s, empty_s, done_s, holder_s, door_s} = sync2_reg;

   blink_divider #(.HALF_CYCLES(BLINK_HALF_CYCLES)) blink_divider_inst (
      .clk(clk),
      .rst(rst),
      .phase(blink)
   );

   // Register bus write side
   assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
   assign wr_ctrl = wr_fire && awaddr_q == `OFF_CTRL && wstrb_q[0];
   assign wr_cmd = wr_fire && awaddr_q == `OFF_CMD && wstrb_q[1:0] == 2'h3;
   assign wr_sel = wr_fire && awaddr_q == `OFF_SELECT && wstrb_q[0]
                   && wdata_q[3:0] >= `SLOT_FIRST && wdata_q[3:0] <= `SLOT_LAST;
   assign wr_fclr = wr_fire && awaddr_q == `OFF_FAULT && wstrb_q[1] && wdata_q[`FAULT_CLR_BIT];
   assign wr_hit = awaddr_q == `OFF_CTRL || awaddr_q == `OFF_CMD || awaddr_q == `OFF_SELECT
                   || awaddr_q == `OFF_FAULT || awaddr_q == `OFF_STATUS || awaddr_q == `OFF_LEDS;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         aw_full_reg <= 1'b0;
         awaddr_q <= 8'h00;
         s_axi_awready <= 1'b0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_full_reg <= 1'b1;
         awaddr_q <= {s_axi_awaddr[7:2], 2'h0};
         s_axi_awready <= 1'b0;
      end
      else
      begin
         if (wr_fire)
            aw_full_reg <= 1'b0;
         if (!aw_full_reg && !s_axi_bvalid)
            s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         w_full_reg <= 1'b0;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         s_axi_wready <= 1'b0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_full_reg <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end
      else
      begin
         if (wr_fire)
            w_full_reg <= 1'b0;
         if (!w_full_reg && !s_axi_bvalid)
            s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Register bus read side
   assign slot_bit = 10'(10'h001 << (slot_reg - 4'h1));
   always_comb
   begin
      rd_hit = 1'b1;
      rd_mux = 32'h00000000;
      unique case ({s_axi_araddr[7:2], 2'h0})
         `OFF_CTRL: rd_mux = {29'h0, loop_reg, restart_reg, seq_mode_reg};
         `OFF_CMD: rd_mux = {15'h0, cmd_pend_reg, cmd_dst_reg, cmd_src_reg, cmd_op_reg};
         `OFF_SELECT: rd_mux = {27'h0, sel_pend_reg, sel_slot_reg};
         `OFF_FAULT: rd_mux = {23'h0, state_reg == ST_FAULT, fault_code_reg};
         `OFF_STATUS: rd_mux = {22'h0, rejected_reg, act_req, slot_reg, state_reg};
         `OFF_LEDS: rd_mux = {22'h0, led};
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rvalid)
      begin
         if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
      else
      begin
         s_axi_arready <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         seq_mode_reg <= `CTRL_SEQ_RST;
         restart_reg <= `CTRL_RESTART_RST;
         loop_reg <= `CTRL_LOOP_RST;
      end
      else if (wr_ctrl)
      begin
         seq_mode_reg <= wdata_q[`CTRL_SEQ_BIT];
         restart_reg <= wdata_q[`CTRL_RESTART_BIT];
         loop_reg <= wdata_q[`CTRL_LOOP_BIT];
      end
   end

   // Host command and operator selection; a new write wins over the take
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cmd_pend_reg <= 1'b0;
         cmd_op_reg <= 8'h00;
         cmd_src_reg <= 4'h0;
         cmd_dst_reg <= 4'h0;
      end
      else if (wr_cmd)
      begin
         cmd_pend_reg <= 1'b1;
         cmd_op_reg <= wdata_q[7:0];
         cmd_src_reg <= wdata_q[11:8];
         cmd_dst_reg <= wdata_q[15:12];
      end
      else if (cmd_ack)
      begin
         cmd_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sel_pend_reg <= 1'b0;
         sel_slot_reg <= `SLOT_FIRST;
      end
      else if (wr_sel)
      begin
         sel_pend_reg <= 1'b1;
         sel_slot_reg <= wdata_q[3:0];
      end
      else if (sel_ack)
      begin
         sel_pend_reg <= 1'b0;
      end
   end

   // Handler action wanted by each state
   always_comb
   begin
      cur_act = ACT_NONE;
      unique case (state_reg)
         ST_SELFTEST: cur_act = ACT_HOME_TOP;
         // pick at source, place at target
         ST_RND_PICK: cur_act = ex_src_reg == `LOC_DRIVE ? ACT_PICK_DRIVE : ACT_PICK_SLOT;
         ST_RND_PLACE: cur_act = ex_dst_reg == `LOC_DRIVE ? ACT_PLACE_DRIVE : ACT_PLACE_SLOT;
         ST_RND_POS: cur_act = ACT_POSITION;
         ST_SEQ_PICK: cur_act = ACT_PICK_SLOT;
         ST_SEQ_INSERT: cur_act = ACT_PLACE_DRIVE;
         ST_SEQ_CLOSE: cur_act = ACT_CLOSE_DOOR;
         ST_SEQ_PARK: cur_act = ACT_PARK;
         ST_SEQ_RETRIEVE: cur_act = ACT_PICK_DRIVE;
         ST_SEQ_RETURN: cur_act = ACT_PLACE_SLOT;
         ST_LAMP, ST_RND_IDLE, ST_SEQ_WAIT, ST_SEQ_REOPEN, ST_SEQ_HALT, ST_FAULT: cur_act = ACT_NONE;
      endcase
   end

   assign cur_loc = state_reg == ST_RND_PICK ? ex_src_reg
                    : (state_reg == ST_RND_PLACE || state_reg == ST_RND_POS) ? ex_dst_reg
                    : (state_reg == ST_SEQ_PICK || state_reg == ST_SEQ_RETURN) ? slot_reg : `LOC_DRIVE;
   assign seq_grp = state_reg >= ST_SEQ_WAIT && state_reg <= ST_SEQ_HALT;
   assign seq_busy = state_reg >= ST_SEQ_PICK && state_reg <= ST_SEQ_RETURN;
   assign cmd_ack = cmd_pend_reg && (state_reg == ST_RND_IDLE || seq_grp);
   assign cmd_ok = state_reg == ST_RND_IDLE && !seq_mode_reg && cmd_dst_reg <= `SLOT_LAST
                   && ((cmd_op_reg == `OP_MOVE && cmd_src_reg <= `SLOT_LAST && cmd_src_reg != cmd_dst_reg)
                       || cmd_op_reg == `OP_POSITION);
   assign sel_ack = sel_pend_reg && (state_reg == ST_SEQ_WAIT || state_reg == ST_SEQ_HALT);
   assign issue = cur_act != ACT_NONE && !act_req && !done_s;
   assign step = cur_act != ACT_NONE && act_req && done_s;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         lamp_cnt_reg <= 28'h0000000;
      else if (state_reg == ST_LAMP)
         lamp_cnt_reg <= lamp_cnt_reg + 28'h0000001;
   end

   // Sequencer
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= ST_LAMP;
         act_req <= 1'b0;
         act_code <= ACT_NONE;
         act_loc <= `LOC_DRIVE;
         slot_reg <= `SLOT_FIRST;
         done_mask_reg <= 10'h000;
         fault_code_reg <= 8'h00;
         rejected_reg <= 1'b0;
         ex_src_reg <= 4'h0;
         ex_dst_reg <= 4'h0;
      end
      else if (act_req && fault_s)
      begin
         state_reg <= ST_FAULT;
         act_req <= 1'b0;
         fault_code_reg <= code_s;
      end
      else
      begin
         if (cmd_ack)
            rejected_reg <= !cmd_ok;
         if (issue)
         begin
            act_req <= 1'b1;
            act_code <= cur_act;
            act_loc <= cur_loc;
         end
         if (step)
            act_req <= 1'b0;
         unique case (state_reg)
            ST_LAMP:
               if (lamp_cnt_reg == 28'(LAMP_CYCLES - 1))
                  state_reg <= ST_SELFTEST;
            ST_SELFTEST:
               if (step)
               begin
                  // bottom on restart or stored slot outside 1 to 10, else stored slot
                  if (restart_reg || nv_resume_slot < `SLOT_FIRST || nv_resume_slot > `SLOT_LAST)
                     slot_reg <= `SLOT_FIRST;
                  else
                     slot_reg <= nv_resume_slot;
                  state_reg <= seq_mode_reg ? ST_SEQ_WAIT : ST_RND_IDLE;
               end
            ST_RND_IDLE:
               if (seq_mode_reg)
                  state_reg <= ST_SEQ_WAIT;
               else if (cmd_ack && cmd_ok)
               begin
                  ex_src_reg <= cmd_src_reg;
                  ex_dst_reg <= cmd_dst_reg;
                  state_reg <= cmd_op_reg == `OP_MOVE ? ST_RND_PICK : ST_RND_POS;
               end
            ST_RND_PICK:
               if (step)
               begin
                  rejected_reg <= empty_s;
                  state_reg <= empty_s ? ST_RND_IDLE : ST_RND_PLACE;
               end
            ST_RND_PLACE, ST_RND_POS:
               if (step)
                  state_reg <= ST_RND_IDLE;
            ST_SEQ_WAIT, ST_SEQ_HALT:
               if (!seq_mode_reg)
                  state_reg <= ST_RND_IDLE;
               else if (holder_s)
               begin
                  slot_reg <= `SLOT_FIRST;
                  done_mask_reg <= 10'h000;
                  state_reg <= ST_SEQ_WAIT;
               end
               else if (sel_ack)
               begin
                  slot_reg <= sel_slot_reg;
                  state_reg <= ST_SEQ_WAIT;
               end
               else if (state_reg == ST_SEQ_WAIT && door_s)
                  state_reg <= ST_SEQ_PICK;
            ST_SEQ_PICK:
               if (step && !empty_s)
                  state_reg <= ST_SEQ_INSERT;
               else if (step && slot_reg != `SLOT_LAST)
                  slot_reg <= slot_reg + 4'h1;
               // wrap or halt after the top
               else if (step)
               begin
                  slot_reg <= `SLOT_FIRST;
                  done_mask_reg <= loop_reg ? 10'h000 : done_mask_reg;
                  state_reg <= loop_reg ? ST_SEQ_WAIT : ST_SEQ_HALT;
               end
            ST_SEQ_INSERT:
               if (step)
                  state_reg <= ST_SEQ_CLOSE;
            ST_SEQ_CLOSE:
               if (step)
                  state_reg <= ST_SEQ_PARK;
            ST_SEQ_PARK:
               if (step)
                  state_reg <= ST_SEQ_REOPEN;
            ST_SEQ_REOPEN:
               if (door_s)
                  state_reg <= ST_SEQ_RETRIEVE;
            ST_SEQ_RETRIEVE:
               if (step)
                  state_reg <= ST_SEQ_RETURN;
            ST_SEQ_RETURN:
               if (step)
               begin
                  if (slot_reg != `SLOT_LAST)
                  begin
                     done_mask_reg <= done_mask_reg | slot_bit;
                     slot_reg <= slot_reg + 4'h1;
                     state_reg <= ST_SEQ_WAIT;
                  end
                  // loop to slot one or stop
                  else
                  begin
                     done_mask_reg <= loop_reg ? 10'h000 : (done_mask_reg | slot_bit);
                     slot_reg <= `SLOT_FIRST;
                     state_reg <= loop_reg ? ST_SEQ_WAIT : ST_SEQ_HALT;
                  end
               end
            ST_FAULT:
               if (wr_fclr)
                  state_reg <= ST_SELFTEST;
         endcase
      end
   end

   // Panel lamps, bit n is lamp n+1 counted from the bottom
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         led <= 10'h000;
      // all lamps on, off once self-test starts
      else if (state_reg == ST_LAMP)
         led <= 10'h3FF;
      // binary weighted code; top lamp, plus lamp 9 for code 0, keeps two or more lit
      else if (state_reg == ST_FAULT)
         led <= blink ? {1'b1, fault_code_reg == 8'h00, fault_code_reg} : 10'h000;
      // steady done, blinking current from pick to return, else off
      else if (seq_grp)
         led <= done_mask_reg | ((seq_busy && blink) ? slot_bit : 10'h000);
      else
         led <= 10'h000;
   end

endmodule : autoloader_sequence_control

// ===== dv/handler_model.sv
// Handler mechanism and drive door model facing the controller
`timescale 1ns/1ps
module handler_model (
   input wire logic clk, // clock
   input wire logic rst, // reset
   input wire logic act_req, // request
   input wire autoloader_pkg::act_t act_code, // action
   input wire logic [3:0] act_loc, // location
   input wire logic [9:0] empty_mask, // empty slots
   input wire logic hold, // stall answers
   output logic done, // action done
   output logic empty, // nothing picked
   output logic door // door open
);
   import autoloader_pkg::*;
   int seed = 65;
   int wait_c = 0;
   int door_c = 0;
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         done <= 1'h0;
         empty <= 1'h0;
         door <= 1'h1;
         door_c = 0;
      end
      else
      begin
         if (door_c > 0)
            door_c = door_c - 1;
         if (door_c == 1)
            door <= 1'h1;
         if (!act_req)
         begin
            done <= 1'h0;
            empty <= 1'h0;
            wait_c = 3 + ($random(seed) & 7);
         end
         else if (!done && !hold && wait_c > 0)
            wait_c = wait_c - 1;
         else if (!done && !hold)
         begin
            done <= 1'h1;
            empty <= act_code == ACT_PICK_SLOT && empty_mask[act_loc - 4'h1];
            if (act_code == ACT_CLOSE_DOOR)
               door <= 1'h0;
            if (act_code == ACT_PARK)
               door_c = 12;
         end
      end
   end
endmodule : handler_model

// ===== dv/autoloader_sequence_control_assertions.sv
// Port checker for the autoloader controller
`timescale 1ns/1ps
module autoloader_assertions #(
   parameter int LAMP_CYCLES = 20
)(
   input wire logic clk, // clock
   input wire logic rst, // reset
   input wire logic s_axi_awvalid, // aw valid
   input wire logic s_axi_awready, // aw ready
   input wire logic s_axi_wvalid, // w valid
   input wire logic s_axi_wready, // w ready
   input wire logic s_axi_bvalid, // b valid
   input wire logic s_axi_bready, // b ready
   input wire logic [7:0] s_axi_araddr, // ar addr
   input wire logic s_axi_arvalid, // ar valid
   input wire logic s_axi_arready, // ar ready
   input wire logic s_axi_rvalid, // r valid
   input wire logic [1:0] s_axi_rresp, // r resp
   input wire logic act_done_pin, // done
   input wire logic act_fault_pin, // fault
   input wire logic act_req, // request
   input wire autoloader_pkg::act_t act_code, // action
   input wire logic [3:0] act_loc, // location
   input wire logic [9:0] led // lamps
);
   import autoloader_pkg::*;
   int cyc;
   logic [1:0] h;
   always_ff @(posedge clk or posedge rst)
      if (rst)
         cyc <= 0;
      else if (cyc < LAMP_CYCLES)
         cyc <= cyc + 1;
   always_ff @(posedge clk or posedge rst)
      if (rst)
         h <= 2'h0;
      else
         h <= {h[0], act_done_pin | act_fault_pin};
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_lamp_test: assert property (cyc >= 1 && cyc < LAMP_CYCLES - 1 |-> led == 10'h3FF)
      else $error("lamps not all lit in lamp test");
   a_req_holds: assert property (act_req && !(act_done_pin || act_fault_pin) && h == 2'h0
      |=> act_req && $stable(act_code) && $stable(act_loc))
      else $error("handler request changed before done");
   a_req_release: assert property (act_req && act_done_pin |-> ##[1:4] !act_req)
      else $error("request not dropped after done");
   a_fault_stop: assert property (act_req && act_fault_pin |-> ##[1:4] !act_req)
      else $error("request not dropped on fault");
   a_req_waits: assert property ($rose(act_req) |-> !act_done_pin)
      else $error("request raised while done high");
   a_write_resp: assert property (wr_taken |-> ##[1:4] s_axi_bvalid)
      else $error("write response missing");
   a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_read_resp: assert property (ar_taken |=> s_axi_rvalid)
      else $error("read data missing");
   a_unmapped_err: assert property (ar_taken and s_axi_araddr >= 8'h18 |=> s_axi_rresp == 2'h2)
      else $error("unmapped read not refused");
endmodule : autoloader_assertions
bind autoloader_sequence_control autoloader_assertions #(.LAMP_CYCLES(LAMP_CYCLES)) autoloader_assertions_inst (
   .clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rresp, .act_done_pin, .act_fault_pin,
   .act_req, .act_code, .act_loc, .led);

// ===== dv/autoloader_sequence_control_tb.sv
// Self-checking bench for the autoloader controller
`timescale 1ns/1ps
module autoloader_sequence_control_tb;
   import autoloader_pkg::*;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, fault_code_pin = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'h0, act_loc;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
   logic s_axi_rready = 1'h0, act_fault_pin = 1'h0, hold = 1'h0, req_q = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic act_done_pin, act_empty_pin, door_open_pin, act_req;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [9:0] led, or_v, and_v, done_m = 10'h000;
   act_t act_code;
   int err_count = 0, cmp_count = 0, ec, el;
   int eq_c[$], eq_l[$];
   always #5 clk = ~clk;
   autoloader_sequence_control #(.LAMP_CYCLES(20), .BLINK_HALF_CYCLES(4)) autoloader_sequence_control_inst (
      .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .door_open_pin, .holder_swap_pin(1'h0),
      .act_done_pin, .act_empty_pin, .act_fault_pin, .fault_code_pin, .nv_resume_slot(4'h2), .act_req,
      .act_code, .act_loc, .led);
   handler_model handler_model_inst (.clk, .rst, .act_req, .act_code, .act_loc, .empty_mask(10'h002), .hold,
      .done(act_done_pin), .empty(act_empty_pin), .door(door_open_pin));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task conclude;
      $display("errors %0d comparisons %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : conclude
   task ex(input int c, input int l);
      eq_c.push_back(c);
      eq_l.push_back(l);
   endtask : ex
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do
      begin
         @(posedge clk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'h0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'h0;
      end
      while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 1'h0;
      @(posedge clk);
   endtask : wr
   task rd_reg(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do
      begin
         @(posedge clk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'h0;
      end
      while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'h0;
      @(posedge clk);
   endtask : rd_reg
   task settle;
      for (int i = 0; i < 400 && (eq_c.size() != 0 || act_req); i++)
         @(posedge clk);
      repeat (10) @(posedge clk);
   endtask : settle
   task watch;
      or_v = 10'h000;
      and_v = 10'h3FF;
      repeat (12)
      begin
         @(posedge clk);
         or_v = or_v | led;
         and_v = and_v & led;
      end
   endtask : watch
   // Action order model at every new request, lamp state at each slot pick request
   always @(posedge clk)
   begin
      req_q <= act_req;
      if (act_req && !req_q)
      begin
         ec = eq_c.size() ? eq_c.pop_front() : 15;
         el = eq_l.size() ? eq_l.pop_front() : -1;
         if (act_code == ACT_PICK_SLOT && act_loc == 4'h1)
            done_m = 10'h000;
         chk({28'h0, act_code}, ec);
         if (el >= 0)
            chk({28'h0, act_loc}, el);
         if (act_code == ACT_PICK_SLOT)
            chk({22'h0, led & ~(10'h001 << (act_loc - 4'h1))}, {22'h0, done_m});
         if (act_code == ACT_PLACE_SLOT)
            done_m[act_loc - 4'h1] = 1'h1;
      end
   end
   initial
   begin
      repeat (30000) @(posedge clk);
      err_count++;
      conclude;
   end
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'h0;
      ex(1, -1);
      repeat (2) @(posedge clk);
      chk({22'h0, led}, 32'h3FF);
      rd_reg(8'h00);
      chk(rd, 32'h2);
      rd_reg(8'h40);
      chk({30'h0, rs}, 32'h2);
      ex(2, 3);
      ex(3, 0);
      wr(8'h04, 32'h0000030A, 4'h3);
      chk({30'h0, rs}, 32'h0);
      settle;
      ex(8, 5);
      wr(8'h04, 32'h0000552B, 4'h3);
      chk({30'h0, rs}, 32'h0);
      settle;
      wr(8'h04, 32'h00000511, 4'h3);
      repeat (4) @(posedge clk);
      rd_reg(8'h10);
      chk({31'h0, rd[9]}, 32'h1);
      hold <= 1'h1;
      ex(8, 7);
      wr(8'h04, 32'h0000772B, 4'h3);
      for (int i = 0; i < 200 && !act_req; i++)
         @(posedge clk);
      act_fault_pin <= 1'h1;
      fault_code_pin <= 8'h8B;
      repeat (8) @(posedge clk);
      rd_reg(8'h0C);
      chk(rd, 32'h18B);
      watch;
      chk({22'h0, or_v}, 32'h28B);
      chk({22'h0, and_v}, 32'h0);
      act_fault_pin <= 1'h0;
      hold <= 1'h0;
      wr(8'h00, 32'h5, 4'h1);
      ex(1, -1);
      for (int s = 2; s <= 10; s++)
      begin
         ex(2, s);
         if (s != 2)
         begin
            ex(3, 0);
            ex(4, -1);
            ex(5, -1);
            ex(6, 0);
            ex(7, s);
         end
      end
      ex(2, 1);
      wr(8'h0C, 32'h100, 4'h2);
      for (int i = 0; i < 2000 && !(act_req && act_code == ACT_PARK); i++)
         @(posedge clk);
      watch;
      chk({22'h0, or_v}, 32'h4);
      chk({22'h0, and_v}, 32'h0);
      wr(8'h04, 32'h0000030A, 4'h3);
      repeat (4) @(posedge clk);
      rd_reg(8'h10);
      chk({31'h0, rd[9]}, 32'h1);
      for (int i = 0; i < 20000 && eq_c.size() != 0; i++)
         @(posedge clk);
      chk(eq_c.size(), 32'h0);
      conclude;
   end
endmodule : autoloader_sequence_control_tb
